// >>> hw/arb_pkg.sv
package arb_pkg;

    // ************************************************************
    // Requesters, lowest index has highest priority
    // ************************************************************
    localparam int NREQ    = 5;
    localparam int REQ_DWR = 0;
    localparam int REQ_PWR = 1;
    localparam int REQ_DRD = 2;
    localparam int REQ_PRD = 3;
    localparam int REQ_FET = 4;
    localparam logic [NREQ-1:0] WR_MASK = 5'h03;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PADDR_W    = 22;
    localparam int DADDR_W    = 32;
    localparam int DATA_W     = 32;
    localparam int PAD_W      = DADDR_W - PADDR_W;
    localparam int PER_ADDR_W = 16;
    localparam int WS_W       = 4;
    localparam int CNT_W      = 5;
    localparam int PAGE_LSB   = 3;
    localparam int PAGE_W     = PADDR_W - PAGE_LSB;
    localparam int OWNER_W    = 3;

    // ************************************************************
    // Regions
    // ************************************************************
    typedef enum logic [3:0] {
        REG_NONE   = 4'h0,
        REG_LOWRAM = 4'h1,
        REG_PF0    = 4'h2,
        REG_PF1    = 4'h3,
        REG_PF2    = 4'h4,
        REG_LOCAL  = 4'h5,
        REG_OTP    = 4'h6,
        REG_FLASH  = 4'h7,
        REG_PWD    = 4'h8,
        REG_BOOT   = 4'h9
    } region_t;

    localparam logic [31:0] LOWRAM_HI = 32'h0000_07FF;
    localparam logic [31:0] PF0_LO    = 32'h0000_0800;
    localparam logic [31:0] PF0_HI    = 32'h0000_1FFF;
    localparam logic [31:0] PF1_LO    = 32'h0000_6000;
    localparam logic [31:0] PF1_HI    = 32'h0000_6FFF;
    localparam logic [31:0] PF2_LO    = 32'h0000_7000;
    localparam logic [31:0] PF2_HI    = 32'h0000_7FFF;
    localparam logic [31:0] LALIAS_LO = 32'h0000_8000;
    localparam logic [31:0] LALIAS_HI = 32'h0000_83FF;
    localparam logic [31:0] OTP_LO    = 32'h003D_7800;
    localparam logic [31:0] OTP_HI    = 32'h003D_7BFF;
    localparam logic [31:0] FLASH_LO  = 32'h003F_0000;
    localparam logic [31:0] FLASH_HI  = 32'h003F_7FF7;
    localparam logic [31:0] PWD_LO    = 32'h003F_7FF8;
    localparam logic [31:0] PWD_HI    = 32'h003F_7FFF;
    localparam logic [31:0] LOCAL_LO  = 32'h003F_8000;
    localparam logic [31:0] LOCAL_HI  = 32'h003F_83FF;
    localparam logic [31:0] BOOT_LO   = 32'h003F_E000;
    localparam logic [31:0] BOOT_HI   = 32'h003F_FFFF;

    // ************************************************************
    // Wait states, protection and frames
    // ************************************************************
    localparam logic [CNT_W-1:0] WS_ZERO  = 5'h00;
    localparam logic [CNT_W-1:0] WS_PF_WR = 5'h00;
    localparam logic [CNT_W-1:0] WS_PF_RD = 5'h02;
    localparam logic [CNT_W-1:0] WS_PWD   = 5'h10;
    localparam logic [WS_W-1:0]  WS_OTP_MIN = 4'h1;
    localparam logic [WS_W-1:0]  WS_RND_MIN = 4'h1;
    localparam logic [1:0] PROT_RESET = 2'h3;
    localparam int PROT_PF1 = 0;
    localparam int PROT_PF2 = 1;
    localparam logic [1:0] FRAME_0 = 2'h0;
    localparam logic [1:0] FRAME_1 = 2'h1;
    localparam logic [1:0] FRAME_2 = 2'h2;

    function automatic region_t region_of(input logic [31:0] a);
        if (a <= LOWRAM_HI) region_of = REG_LOWRAM;
        else if (a >= PF0_LO && a <= PF0_HI) region_of = REG_PF0;
        else if (a >= PF1_LO && a <= PF1_HI) region_of = REG_PF1;
        else if (a >= PF2_LO && a <= PF2_HI) region_of = REG_PF2;
        else if (a >= LALIAS_LO && a <= LALIAS_HI) region_of = REG_LOCAL;
        else if (a >= OTP_LO && a <= OTP_HI) region_of = REG_OTP;
        else if (a >= FLASH_LO && a <= FLASH_HI) region_of = REG_FLASH;
        else if (a >= PWD_LO && a <= PWD_HI) region_of = REG_PWD;
        else if (a >= LOCAL_LO && a <= LOCAL_HI) region_of = REG_LOCAL;
        else if (a >= BOOT_LO && a <= BOOT_HI) region_of = REG_BOOT;
        else region_of = REG_NONE;
    endfunction

    // All frames share the one peripheral bridge
    function automatic region_t res_of(input region_t r);
        res_of = (r == REG_PF1 || r == REG_PF2) ? REG_PF0 : r;
    endfunction

endpackage

// >>> hw/wait_timer.sv
`timescale 1ns/1ps
module wait_timer
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    // Control
    input  wire logic                      start,
    input  wire logic [arb_pkg::CNT_W-1:0] load,
    input  wire logic                      hold,
    // Status
    output logic                           busy,
    output logic                           last,
    output logic                           done
);
    logic [arb_pkg::CNT_W-1:0] cnt;

    // Ready only stretches the final cycle
    assign last = busy & (cnt == arb_pkg::WS_ZERO) & ~hold;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy <= 1'b0;
            cnt  <= arb_pkg::WS_ZERO;
            done <= 1'b0;
        end
        else
        begin
            done <= last;
            if (start)
            begin
                busy <= 1'b1;
                cnt  <= load;
            end
            else if (last)
                busy <= 1'b0;
            else if (busy && cnt != arb_pkg::WS_ZERO)
                cnt <= cnt - 5'h01;
        end
    end
endmodule // wait_timer

// >>> hw/mem_bus_arbiter.sv
`timescale 1ns/1ps
// Operation
// RL1 - With passwords, loader fills block below password with zero words only.
// RL2 - Pipeline may let a read overtake the preceding write.
// RL3 - Protected frames see accesses in program order; alignment cycles inserted.
// RL4 - Ordering protection programmable, enabled for both zones after reset.
// RL5 - First protected frame: writes zero waits, reads two, ready stretches.
// RL6 - Back-to-back writes to first protected frame stall one cycle.
// RL7 - Second protected frame: writes zero, reads two, no stretching.
// RL8 - Local shared RAM zero waits for data and program without conflict; code arbitrates it as one memory, so they can stall each other.
// RL9 - One-time memory waits configurable, never fewer than one.
// RL10 - Flash paged min zero, random min one, random not below paged.
// RL11 - Password reads always take sixteen wait states.
// RL12 - Program bus has 22 address and 32 data bits.
// RL13 - Data read and write buses have 32 address and data bits.
// RL14 - Fetch, data read and data write may proceed in one cycle.
// RL15 - Priority: data write, program write, data read, program read, fetch.
// RL16 - Data write and program write never presented together.
// RL17 - Program read and fetch never presented together.
// RL18 - Bridge folds buses into one 16-bit-address peripheral bus.
// RL19 - Second frame accepts 16-bit accesses only.
// RL20 - First frame accepts 16-bit and 32-bit accesses.
// RL21 - Eight-stage pipeline with pipelined memory accesses on the core side.
// RL22 - Each wait state holds the access and stalls lower requesters.
// RL23 - Zero-wait RAMs, unprotected frame and boot ROM complete next cycle.
module mem_bus_arbiter
(
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           arst_n,
    // Core requests
    input  wire logic [arb_pkg::NREQ-1:0]       req,
    input  wire logic [arb_pkg::DADDR_W-1:0]    dwrite_addr,
    input  wire logic [arb_pkg::DATA_W-1:0]     dwrite_data,
    input  wire logic                           dwrite_size32,
    input  wire logic [arb_pkg::PADDR_W-1:0]    pwrite_addr,
    input  wire logic [arb_pkg::DADDR_W-1:0]    dread_addr,
    input  wire logic                           dread_size32,
    input  wire logic [arb_pkg::PADDR_W-1:0]    pread_addr,
    input  wire logic [arb_pkg::PADDR_W-1:0]    fetch_addr,
    // Configuration
    input  wire logic [arb_pkg::WS_W-1:0]       flash_paged_ws,
    input  wire logic [arb_pkg::WS_W-1:0]       flash_random_ws,
    input  wire logic [arb_pkg::WS_W-1:0]       otp_ws,
    input  wire logic                           prot_load,
    input  wire logic [1:0]                     prot_zone_in,
    // Core answers
    output logic [arb_pkg::NREQ-1:0]            present,
    output logic [arb_pkg::NREQ-1:0]            done,
    output logic [arb_pkg::DATA_W-1:0]          read_data,
    output logic                                size_err,
    // Peripheral bus
    output logic [arb_pkg::PER_ADDR_W-1:0]      per_addr,
    output logic [arb_pkg::DATA_W-1:0]          per_wdata,
    output logic                                per_rd,
    output logic                                per_wr,
    output logic                                per_size32,
    output logic [1:0]                          per_frame,
    input  wire logic                           per_ready,
    input  wire logic [arb_pkg::DATA_W-1:0]     per_rdata
);
    localparam int N = arb_pkg::NREQ;

    logic [arb_pkg::DADDR_W-1:0] a32     [N];
    logic [arb_pkg::CNT_W-1:0]   ws      [N];
    arb_pkg::region_t            reg_new [N];
    arb_pkg::region_t            reg_q   [N];
    logic [N-1:0]                wr_req;
    logic [N-1:0]                sz;
    logic [N-1:0]                live;
    logic [N-1:0]                start;
    logic [N-1:0]                hold;
    logic [N-1:0]                last;
    logic [N-1:0]                conflict;
    logic [N-1:0]                higher;
    logic [N-1:0]                excl;
    logic [N-1:0]                order_blk;
    logic [N-1:0]                paged;
    logic [N-1:0]                per_start;
    logic [1:0]                  prot_zone;
    logic                        pf1_gap;
    logic                        pf1_wr_fin;
    logic                        wr_prot_act;
    logic [arb_pkg::PAGE_W-1:0]  flash_page;
    logic                        flash_page_ok;
    logic [arb_pkg::WS_W-1:0]    rnd_lo;
    logic [arb_pkg::WS_W-1:0]    rnd_eff;
    logic [arb_pkg::WS_W-1:0]    otp_eff;
    logic [arb_pkg::OWNER_W-1:0] per_idx;
    logic [arb_pkg::OWNER_W-1:0] per_owner;
    logic                        per_go;
    logic                        per_busy;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic is_prot(input arb_pkg::region_t r, input logic [1:0] z);
        is_prot = (r == arb_pkg::REG_PF1 && z[arb_pkg::PROT_PF1]) ||
                  (r == arb_pkg::REG_PF2 && z[arb_pkg::PROT_PF2]);
    endfunction

    function automatic logic is_per(input arb_pkg::region_t r);
        is_per = (arb_pkg::res_of(r) == arb_pkg::REG_PF0);
    endfunction

    function automatic logic [arb_pkg::CNT_W-1:0] waits_of(input arb_pkg::region_t r,
            input logic wr, input logic pg, input logic [arb_pkg::WS_W-1:0] pws,
            input logic [arb_pkg::WS_W-1:0] rws, input logic [arb_pkg::WS_W-1:0] ows);
        unique case (r)
            arb_pkg::REG_PF1,
            arb_pkg::REG_PF2:   waits_of = wr ? arb_pkg::WS_PF_WR : arb_pkg::WS_PF_RD; // [RL5] [RL7]
            arb_pkg::REG_OTP:   waits_of = {1'b0, ows};                 // [RL9]
            arb_pkg::REG_FLASH: waits_of = {1'b0, pg ? pws : rws};      // [RL10]
            arb_pkg::REG_PWD:   waits_of = arb_pkg::WS_PWD;             // [RL11]
            default:            waits_of = arb_pkg::WS_ZERO;            // [RL8] [RL23]
        endcase
    endfunction

    // ************************************************************
    // Address widening and configuration clamps
    // ************************************************************
    assign a32[arb_pkg::REQ_DWR] = dwrite_addr;                           // [RL13]
    assign a32[arb_pkg::REQ_PWR] = {{arb_pkg::PAD_W{1'b0}}, pwrite_addr}; // [RL12]
    assign a32[arb_pkg::REQ_DRD] = dread_addr;                            // [RL13]
    assign a32[arb_pkg::REQ_PRD] = {{arb_pkg::PAD_W{1'b0}}, pread_addr};  // [RL12]
    assign a32[arb_pkg::REQ_FET] = {{arb_pkg::PAD_W{1'b0}}, fetch_addr};  // [RL12]
    assign wr_req = arb_pkg::WR_MASK;
    // Program side always moves full words
    assign sz = {1'b1, 1'b1, dread_size32, 1'b1, dwrite_size32};

    // Misprogrammed settings are raised rather than trusted
    assign rnd_lo  = (flash_random_ws < flash_paged_ws) ? flash_paged_ws : flash_random_ws;
    assign rnd_eff = (rnd_lo < arb_pkg::WS_RND_MIN) ? arb_pkg::WS_RND_MIN : rnd_lo; // [RL10]
    assign otp_eff = (otp_ws < arb_pkg::WS_OTP_MIN) ? arb_pkg::WS_OTP_MIN : otp_ws; // [RL9]

    // ************************************************************
    // Per-requester decode and timers
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_req
            assign reg_new[g] = arb_pkg::region_of(a32[g]);
            // One outstanding access per requester keeps the core pipeline flowing
            assign live[g]  = req[g] & ~present[g] & ~done[g]; // [RL21]
            assign paged[g] = flash_page_ok &
                              (a32[g][arb_pkg::PADDR_W-1:arb_pkg::PAGE_LSB] == flash_page);
            assign ws[g]    = waits_of(reg_new[g], wr_req[g], paged[g],
                                       flash_paged_ws, rnd_eff, otp_eff);
            assign hold[g]  = (reg_q[g] == arb_pkg::REG_PF1) & ~per_ready; // [RL5]
            assign order_blk[g] = wr_req[g] ?
                ((pf1_wr_fin | pf1_gap) & (reg_new[g] == arb_pkg::REG_PF1)) :  // [RL6]
                (wr_prot_act & is_prot(reg_new[g], prot_zone));                // [RL3]
            assign start[g] = live[g] & ~conflict[g] & ~higher[g] & ~excl[g] & ~order_blk[g];
            assign per_start[g] = start[g] & is_per(reg_new[g]);

            // Independent timers let fetch, data read and data write run in the same cycle
            wait_timer u_timer                                     // [RL14] [RL22]
            (
                .clk    (clk),
                .arst_n (arst_n),
                .start  (start[g]),
                .load   (ws[g]),
                .hold   (hold[g]),
                .busy   (present[g]),
                .last   (last[g]),
                .done   (done[g])
            );
        end
    endgenerate

    // ************************************************************
    // Arbitration
    // ************************************************************
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            conflict[i] = 1'b0;
            higher[i]   = 1'b0;
            for (int j = 0; j < N; j++)
            begin
                // A pending access keeps its memory until the last wait state
                if (present[j] && reg_new[i] != arb_pkg::REG_NONE &&
                    arb_pkg::res_of(reg_q[j]) == arb_pkg::res_of(reg_new[i]))
                    conflict[i] = 1'b1; // [RL22] [RL8]
                if (j < i && live[j] && reg_new[i] != arb_pkg::REG_NONE &&
                    arb_pkg::res_of(reg_new[j]) == arb_pkg::res_of(reg_new[i]))
                    higher[i] = 1'b1;   // [RL15]
            end
        end
    end

    assign excl[arb_pkg::REQ_DWR] = present[arb_pkg::REQ_PWR];                          // [RL16]
    assign excl[arb_pkg::REQ_PWR] = live[arb_pkg::REQ_DWR] | present[arb_pkg::REQ_DWR]; // [RL16]
    assign excl[arb_pkg::REQ_DRD] = 1'b0;
    assign excl[arb_pkg::REQ_PRD] = present[arb_pkg::REQ_FET];                          // [RL17]
    assign excl[arb_pkg::REQ_FET] = live[arb_pkg::REQ_PRD] | present[arb_pkg::REQ_PRD]; // [RL17]

    // ************************************************************
    // Write/read ordering
    // ************************************************************
    // A protected-frame read must not overtake a protected-frame write still waiting, in flight or just retired
    assign wr_prot_act =
        ((live[arb_pkg::REQ_DWR] | present[arb_pkg::REQ_DWR]) &
         is_prot(reg_new[arb_pkg::REQ_DWR], prot_zone)) |
        ((live[arb_pkg::REQ_PWR] | present[arb_pkg::REQ_PWR]) &
         is_prot(reg_new[arb_pkg::REQ_PWR], prot_zone)) |
        ((present[arb_pkg::REQ_DWR] | done[arb_pkg::REQ_DWR]) &
         is_prot(reg_q[arb_pkg::REQ_DWR], prot_zone)) |
        ((present[arb_pkg::REQ_PWR] | done[arb_pkg::REQ_PWR]) &
         is_prot(reg_q[arb_pkg::REQ_PWR], prot_zone)); // [RL2] [RL3]

    assign pf1_wr_fin =
        (done[arb_pkg::REQ_DWR] & (reg_q[arb_pkg::REQ_DWR] == arb_pkg::REG_PF1)) |
        (done[arb_pkg::REQ_PWR] & (reg_q[arb_pkg::REQ_PWR] == arb_pkg::REG_PF1)); // [RL6]

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prot_zone <= arb_pkg::PROT_RESET; // [RL4]
            pf1_gap   <= 1'b0;
        end
        else
        begin
            if (prot_load)
                prot_zone <= prot_zone_in;    // [RL4]
            pf1_gap <= pf1_wr_fin;            // [RL6]
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            for (int i = 0; i < N; i++)
                reg_q[i] <= arb_pkg::REG_NONE;
        else
            for (int i = 0; i < N; i++)
                if (start[i])
                    reg_q[i] <= reg_new[i];
    end

    // ************************************************************
    // Flash page tracking
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flash_page    <= '0;
            flash_page_ok <= 1'b0;
        end
        else
            for (int i = 0; i < N; i++)
                if (start[i] && reg_new[i] == arb_pkg::REG_FLASH)
                begin
                    flash_page    <= a32[i][arb_pkg::PADDR_W-1:arb_pkg::PAGE_LSB];
                    flash_page_ok <= 1'b1;
                end
    end

    // ************************************************************
    // Peripheral bridge
    // ************************************************************
    always_comb
    begin
        per_idx = '0;
        for (int i = N - 1; i >= 0; i--)
            if (per_start[i])
                per_idx = arb_pkg::OWNER_W'(i);
    end

    assign per_go   = |per_start;
    assign per_busy = per_rd | per_wr;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            per_addr   <= '0;
            per_wdata  <= '0;
            per_rd     <= 1'b0;
            per_wr     <= 1'b0;
            per_size32 <= 1'b0;
            per_frame  <= arb_pkg::FRAME_0;
            per_owner  <= '0;
            size_err   <= 1'b0;
            read_data  <= '0;
        end
        else
        begin
            size_err <= 1'b0;
            if (per_busy && last[per_owner])
            begin
                per_rd <= 1'b0;
                per_wr <= 1'b0;
                if (per_rd)
                    read_data <= per_rdata;
            end
            if (per_go)
            begin
                per_addr   <= a32[per_idx][arb_pkg::PER_ADDR_W-1:0];     // [RL18]
                per_wdata  <= dwrite_data;                               // [RL13]
                per_wr     <= wr_req[per_idx];
                per_rd     <= ~wr_req[per_idx];
                per_owner  <= per_idx;
                // Wide access to the narrow frame runs as 16-bit, flagged
                per_size32 <= sz[per_idx] &
                              (reg_new[per_idx] != arb_pkg::REG_PF2);    // [RL19] [RL20]
                size_err   <= sz[per_idx] &
                              (reg_new[per_idx] == arb_pkg::REG_PF2);    // [RL19]
                per_frame  <= (reg_new[per_idx] == arb_pkg::REG_PF1) ? arb_pkg::FRAME_1 :
                              (reg_new[per_idx] == arb_pkg::REG_PF2) ? arb_pkg::FRAME_2 :
                              arb_pkg::FRAME_0;                          // [RL18]
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    write_excl_a: assert property (!(present[0] && present[1])) // [RL16]
        else $error("data and program write presented together");
    read_excl_a: assert property (!(present[3] && present[4])) // [RL17]
        else $error("program read and fetch presented together");
    narrow_frame_a: assert property (per_busy && per_frame == arb_pkg::FRAME_2 |-> !per_size32) // [RL19]
        else $error("32-bit access on narrow frame");
    pwd_wait_a: assert property (start[2] && reg_new[2] == arb_pkg::REG_PWD |-> ##18 done[2]) // [RL11]
        else $error("password read not sixteen waits");
    pf2_read_a: assert property (start[2] && reg_new[2] == arb_pkg::REG_PF2 |-> ##4 done[2]) // [RL7]
        else $error("second frame read timing wrong");
    boot_zero_a: assert property (start[4] && reg_new[4] == arb_pkg::REG_BOOT |-> ##2 done[4]) // [RL23]
        else $error("boot fetch not zero wait");
    otp_min_a: assert property (start[3] && reg_new[3] == arb_pkg::REG_OTP |-> // [RL9]
                                ##1 !done[3] [*2])
        else $error("otp read below one wait");
    pf1_stall_a: assert property (pf1_gap |-> // [RL6]
                                  !(start[0] && reg_new[0] == arb_pkg::REG_PF1) &&
                                  !(start[1] && reg_new[1] == arb_pkg::REG_PF1))
        else $error("back-to-back frame write not stalled");
    prot_order_a: assert property (present[0] && is_prot(reg_q[0], prot_zone) |->
                                   !(start[2] && is_prot(reg_new[2], prot_zone))) // [RL3]
        else $error("protected read overtook write");
    ready_hold_a: assert property (present[0] && hold[0] |=> !done[0]) // [RL5]
        else $error("write retired while ready low");
    prio_a: assert property (start[2] && start[4] && reg_new[2] != arb_pkg::REG_NONE |->
                             arb_pkg::res_of(reg_new[2]) != arb_pkg::res_of(reg_new[4])) // [RL15]
        else $error("two requesters started on one memory");
endmodule // mem_bus_arbiter

// >>> tb/per_model.sv
`timescale 1ns/1ps
module per_model
(
    // Peripheral bus
    input  wire logic        clk,
    input  wire logic        per_rd,
    input  wire logic        per_wr,
    input  wire logic [1:0]  per_frame,
    // Control from bench
    input  wire logic [1:0]  slow,
    output logic             per_ready,
    output logic [31:0]      per_rdata
);
    logic [1:0]  cnt  = 2'h0;
    logic [31:0] junk = 32'h0;
    // Only frame 1 counts, so frame 2 sees ready low as well
    always_ff @(posedge clk)
    begin
        cnt  <= ((per_rd | per_wr) && per_frame == 2'h1) ? cnt + 2'h1 : 2'h0;
        junk <= ~junk;
    end
    assign per_ready = (cnt >= slow);
    // Idle data toggles so a stale sample cannot match
    assign per_rdata = per_rd ? 32'h5A5A_C3C3 : junk;
endmodule // per_model

// >>> tb/test_mem_bus_arbiter.sv
`timescale 1ns/1ps
module test_mem_bus_arbiter;
    logic clk = 1'b0, arst_n = 1'b0, rdy, sz = 1'b0;
    logic [4:0] req = 5'h00, pres, done;
    logic [31:0] a = 32'h0, d = 32'h0, rdat, rd, wd, seed = 32'h76A373F3;
    logic [15:0] paddr;
    logic [1:0] frame, slow = 2'h0;
    logic [3:0] ows = 4'h0;
    logic prd, pwr, ps32, serr, serr_seen = 1'b0;
    int n_errors = 0, num_checks = 0;
    always #50 clk = ~clk;
    // Size error is a one-cycle pulse, so keep a sticky copy
    always @(posedge clk)
        if (serr)
            serr_seen <= 1'b1;
    per_model p_u (.clk(clk), .per_rd(prd), .per_wr(pwr), .per_frame(frame), .slow(slow),
        .per_ready(rdy), .per_rdata(rdat));
    mem_bus_arbiter dut_u (.clk(clk), .arst_n(arst_n), .req(req), .dwrite_addr(a),
        .dwrite_data(d), .dwrite_size32(sz), .pwrite_addr(a[21:0]), .dread_addr(a),
        .dread_size32(sz), .pread_addr(a[21:0]), .fetch_addr(a[21:0]),
        .flash_paged_ws(4'h0), .flash_random_ws(4'h2), .otp_ws(ows), .prot_load(1'b0),
        .prot_zone_in(2'h3), .present(pres), .done(done), .read_data(rd),
        .size_err(serr), .per_addr(paddr), .per_wdata(wd), .per_rd(prd), .per_wr(pwr),
        .per_size32(ps32), .per_frame(frame), .per_ready(rdy), .per_rdata(rdat));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Counts cycles from request to done pulse
    task automatic acc(input int i, input logic [31:0] ad, input int exp);
        int n;
        n = 0;
        a = ad;
        req[i] = 1'b1;
        do
        begin
            @(posedge clk);
            #10;
            n++;
        end while (done[i] !== 1'b1 && n < 40);
        chk("latency", n, exp);
        @(posedge clk);
        #10 req[i] = 1'b0;
        // Idle cycle so a following request never re-raises in the same step
        @(posedge clk);
        #10;
    endtask
    task automatic complete_run;
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #1000000;
        n_errors++;
        complete_run;
    end
    initial
    begin
        repeat (10) @(posedge clk);
        #10 arst_n = 1'b1;
        acc(4, 32'h003F_E000, 2);
        acc(2, 32'h003F_8010, 2);
        acc(2, 32'h0000_0900, 2);
        slow = 2'h2;
        sz = 1'b1;
        acc(2, 32'h0000_7004, 4);
        chk("rdata", rd[15:0], 32'hC3C3);
        chk("narrow", ps32, 1'b0);
        chk("size_err", serr_seen, 1'b1);
        chk("frame", frame, 2'h2);
        acc(0, 32'h0000_6008, 4);
        chk("wide", ps32, 1'b1);
        chk("paddr", paddr, 16'h6008);
        // Ready late enough to stretch past the two read waits
        slow = 2'h3;
        acc(2, 32'h0000_6010, 5);
        acc(2, 32'h003F_7FF8, 18);
        acc(3, 32'h003D_7800, 3);
        ows = 4'h3;
        acc(3, 32'h003D_7900, 5);
        // Flash reads stay clear of the zero-filled block
        acc(2, 32'h003F_0000, 4);
        acc(2, 32'h003F_0004, 2);
        slow = 2'h0;
        // Low RAM pair, then a frame-1 pair that must see the write stall
        for (int k = 0; k < 2; k++)
        begin
            a = k ? 32'h0000_6008 : 32'h0000_0100;
            req = 5'h03;
            @(posedge done[0] or posedge done[1]);
            #10 chk("first", done, 5'h01);
            chk("excl", pres[1], 1'b0);
            @(posedge clk);
            #10 req[0] = 1'b0;
            repeat (k ? 3 : 1) @(posedge clk);
            #10 chk("second", done, 5'h02);
            @(posedge clk);
            #10 req = 5'h00;
            @(posedge clk);
            #10;
        end
        repeat (20)
        begin
            seed = lfsr(seed);
            d = seed;
            sz = seed[31];
            acc(seed[1:0] == 2'h1 ? 1 : 0, {20'h0, seed[11:0]}, 2);
            if (seed[11])
            begin
                chk("paddr", paddr, {20'h0, seed[11:0]});
                chk("wdata", wd, d);
                chk("size32", ps32, seed[1:0] == 2'h1 || sz);
                chk("frame", frame, 2'h0);
            end
        end
        complete_run;
    end
endmodule // test_mem_bus_arbiter
